//--- rtl/spc_flash_ctrl.sv
// Self-programming flash control: reset-vector choice, control/status
// register, temporary page buffer and command sequencing.
// Assumes core strobes and flash-array signals share clk; fuse and boot pin
// inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps

module spc_flash_ctrl #(
	parameter int PAGE_WORDS = 64,
	parameter logic [15:0] BOOT_RESET_ADDR = 16'h3000,
	parameter logic [15:0] NO_READ_WHILE_WRITE_AREA_START = 16'h3000
) (
	// System
	input wire logic clk,
	input wire logic reset_n,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Processor core
	input wire spc_pkg::spc_core_req_t coreReq,
	input wire logic globalIrqEnable,
	output logic loadValid,
	output logic [7:0] loadData,
	output logic cpuHalt,
	output logic progReadyIrq,
	output logic rwAreaBlocked,
	// Fuses, boot pin and reset vector
	input wire logic bootVectorFuse,
	input wire logic hwBootEnableFuse,
	input wire logic hwBootPin,
	output logic [15:0] resetVector,
	// Flash array
	output spc_pkg::spc_flash_op_t flashOp,
	input wire logic flashOpDone,
	input wire logic [7:0] lockBitsIn,
	input wire logic [7:0] fuseLowIn,
	input wire logic [7:0] sigRowData,
	output logic [15:0] sigRowAddr,
	input wire logic [$clog2(PAGE_WORDS)-1:0] bufReadAddr,
	output logic [15:0] bufReadData
);

	localparam int IDX_W = $clog2(PAGE_WORDS);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (PAGE_WORDS < 2 || (1 << IDX_W) != PAGE_WORDS ||
		IDX_W + 2 > spc_pkg::PTR_W) begin : g_bad_page
		$error("PAGE_WORDS must be a power of two that fits the pointer");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	spc_pkg::spc_state_t state;
	logic irqEnable;
	logic busy;
	logic [5:0] cmd;
	logic [2:0] winCnt;
	logic [2:0] pinSync1;
	logic [2:0] pinSync2;
	logic inReset;
	logic opNrww;
	logic [15:0] pageBuf [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] bufWritten;
	logic bufClear;
	logic bufStore;
	logic wrCtrl;
	logic acceptCmd;
	logic validCmd;
	logic storeHit;
	logic loadHit;
	logic [IDX_W-1:0] wordIdx;
	logic [15:0] pageAddr;
	logic ptrNrww;
	logic [31:0] next_readdata;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Word index drops pointer bit 0; page bits sit above it
	assign wordIdx = coreReq.pointer[IDX_W:1];
	assign pageAddr = {coreReq.pointer[spc_pkg::PTR_W-1:IDX_W+1],
		{(IDX_W+1){1'b0}}};
	assign ptrNrww = coreReq.pointer >= NO_READ_WHILE_WRITE_AREA_START;
	assign wrCtrl = avs_write && !avs_waitrequest &&
		avs_address == spc_pkg::CTRL_OFFSET;
	// Signature read rides only on the plain enable pattern
	assign validCmd = avs_writedata[spc_pkg::SIG_BIT] ?
		avs_writedata[4:0] == spc_pkg::CMD_FILL :
		(avs_writedata[4:0] == spc_pkg::CMD_FILL ||
		avs_writedata[4:0] == spc_pkg::CMD_ERASE ||
		avs_writedata[4:0] == spc_pkg::CMD_WRITE ||
		avs_writedata[4:0] == spc_pkg::CMD_LOCK ||
		avs_writedata[4:0] == spc_pkg::CMD_REEN);
	// A second command while one is armed is dropped, never queued
	assign acceptCmd = wrCtrl && validCmd &&
		state == spc_pkg::SPC_IDLE;
	assign storeHit = coreReq.store && state == spc_pkg::SPC_ARMED;
	assign loadHit = coreReq.load && state == spc_pkg::SPC_ARMED &&
		winCnt > spc_pkg::LOAD_LIMIT && (cmd[spc_pkg::SIG_BIT] ||
		cmd[4:0] == spc_pkg::CMD_LOCK);
	assign bufStore = storeHit && cmd == {1'b0, spc_pkg::CMD_FILL};
	// Re-enable command write or page write done: buffer forgets contents
	assign bufClear = (acceptCmd &&
		avs_writedata[4:0] == spc_pkg::CMD_REEN) ||
		(state == spc_pkg::SPC_BUSY && flashOpDone &&
		flashOp.kind == spc_pkg::SPC_OP_WRITE);

	// ------------------------------------------------------------------
	// Avalon slave: one wait cycle, then the transfer completes
	// ------------------------------------------------------------------
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avs_address)
			spc_pkg::CTRL_OFFSET: next_readdata = {24'h00_0000, irqEnable,
				busy, cmd};
			spc_pkg::BOOT_OFFSET: next_readdata = {16'h0000, resetVector};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Boot selection
	// ------------------------------------------------------------------
	// Fuses and pin cross in; fuses are read only, no write path exists
	always_ff @(posedge clk) begin
		pinSync1 <= {bootVectorFuse, hwBootEnableFuse, hwBootPin};
		pinSync2 <= pinSync1;
	end

	// Vector decided at the first edge after release of reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inReset <= 1'b1;
			resetVector <= spc_pkg::APP_RESET_ADDR;
		end else if (inReset) begin
			inReset <= 1'b0;
			if (!pinSync2[2] || (!pinSync2[1] && !pinSync2[0])) begin
				resetVector <= BOOT_RESET_ADDR;
			end else begin
				resetVector <= spc_pkg::APP_RESET_ADDR;
			end
		end
	end

	// ------------------------------------------------------------------
	// Control register and command sequencer
	// ------------------------------------------------------------------
	// Interrupt enable may change at any time, even mid-operation
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irqEnable <= spc_pkg::CTRL_RESET[spc_pkg::IRQ_EN_BIT];
		end else if (wrCtrl) begin
			irqEnable <= avs_writedata[spc_pkg::IRQ_EN_BIT];
		end
	end

	// Window starts at the write edge and closes after four cycles
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= spc_pkg::SPC_IDLE;
			cmd <= spc_pkg::CTRL_RESET[5:0];
			winCnt <= 3'h0;
		end else begin
			unique case (state)
				spc_pkg::SPC_IDLE: begin
					if (acceptCmd) begin
						state <= spc_pkg::SPC_ARMED;
						cmd <= avs_writedata[5:0];
						winCnt <= spc_pkg::STORE_WIN;
					end
				end
				spc_pkg::SPC_ARMED: begin
					winCnt <= winCnt - 3'h1;
					if (storeHit && (cmd == {1'b0, spc_pkg::CMD_ERASE} ||
						cmd == {1'b0, spc_pkg::CMD_WRITE} ||
						cmd == {1'b0, spc_pkg::CMD_LOCK})) begin
						state <= spc_pkg::SPC_BUSY;
					end else if (storeHit || loadHit || winCnt == 3'h1) begin
						state <= spc_pkg::SPC_IDLE;
						cmd <= 6'h00;
					end
				end
				spc_pkg::SPC_BUSY: begin
					// Enable and command bits stay up until the array is done
					if (flashOpDone) begin
						state <= spc_pkg::SPC_IDLE;
						cmd <= 6'h00;
					end
				end
			endcase
		end
	end

	// Busy: set by an erase or write start outside the no-read-while-write area, cleared by a fill or re-enable store
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy <= spc_pkg::CTRL_RESET[spc_pkg::BUSY_BIT];
		end else if (storeHit && !ptrNrww &&
			(cmd == {1'b0, spc_pkg::CMD_ERASE} ||
			cmd == {1'b0, spc_pkg::CMD_WRITE})) begin
			busy <= 1'b1;
		end else if (bufStore ||
			(storeHit && cmd == {1'b0, spc_pkg::CMD_REEN})) begin
			busy <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Flash array request, latched at the start
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flashOp <= '0;
			opNrww <= 1'b0;
		end else begin
			flashOp.start <= 1'b0;
			if (storeHit && cmd == {1'b0, spc_pkg::CMD_ERASE}) begin
				flashOp.start <= 1'b1;
				flashOp.kind <= spc_pkg::SPC_OP_ERASE;
				flashOp.page <= pageAddr;
				opNrww <= ptrNrww;
			end else if (storeHit && cmd == {1'b0, spc_pkg::CMD_WRITE}) begin
				flashOp.start <= 1'b1;
				flashOp.kind <= spc_pkg::SPC_OP_WRITE;
				flashOp.page <= pageAddr;
				opNrww <= ptrNrww;
			end else if (storeHit && cmd == {1'b0, spc_pkg::CMD_LOCK}) begin
				// Pointer and high data byte play no part here
				flashOp.start <= 1'b1;
				flashOp.kind <= spc_pkg::SPC_OP_LOCK;
				flashOp.lockData <= coreReq.dataPair[7:0];
				opNrww <= 1'b0;
			end
		end
	end

	// Halt while an erase or write targets the no-read-while-write area
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cpuHalt <= 1'b0;
		end else begin
			cpuHalt <= (flashOp.start && opNrww) ||
				(cpuHalt && !flashOpDone);
		end
	end

	// Status outputs seen by the core
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			progReadyIrq <= 1'b0;
			rwAreaBlocked <= 1'b0;
		end else begin
			progReadyIrq <= irqEnable && globalIrqEnable && !cmd[0];
			rwAreaBlocked <= busy;
		end
	end

	// ------------------------------------------------------------------
	// Special loads: lock, fuse and signature bytes
	// ------------------------------------------------------------------
	// Signature address trails the pointer by one cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			loadValid <= 1'b0;
			loadData <= 8'h00;
			sigRowAddr <= 16'h0000;
		end else begin
			sigRowAddr <= coreReq.pointer;
			loadValid <= loadHit;
			if (loadHit && cmd[spc_pkg::SIG_BIT]) begin
				loadData <= sigRowData;
			end else if (loadHit) begin
				loadData <= coreReq.pointer[0] ? lockBitsIn : fuseLowIn;
			end
		end
	end

	// ------------------------------------------------------------------
	// Temporary page buffer
	// ------------------------------------------------------------------
	// Each word takes one write between clears; later writes are dropped
	for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_buf
		always_ff @(posedge clk) begin
			if (!reset_n || bufClear) begin
				bufWritten[i] <= 1'b0;
			end else if (bufStore && wordIdx == IDX_W'(i) &&
				!bufWritten[i]) begin
				bufWritten[i] <= 1'b1;
				pageBuf[i] <= coreReq.dataPair;
			end
		end
	end

	// Array reads the buffer; a cleared word reads as zero, stale data hidden
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bufReadData <= 16'h0000;
		end else if (bufWritten[bufReadAddr]) begin
			bufReadData <= pageBuf[bufReadAddr];
		end else begin
			bufReadData <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence lock_armed_s;
		acceptCmd && avs_writedata[5:0] == {1'b0, spc_pkg::CMD_LOCK};
	endsequence

	sequence quiet_s;
		!coreReq.store && !coreReq.load;
	endsequence

	irq_level_a: assert property (
		irqEnable && globalIrqEnable && !cmd[0] |=> progReadyIrq)
		else $error("ready interrupt not requested");

	busy_set_a: assert property (
		storeHit && !ptrNrww && cmd == {1'b0, spc_pkg::CMD_WRITE}
		|=> busy ##1 rwAreaBlocked)
		else $error("busy flag not set on write start");

	busy_hold_a: assert property (
		state == spc_pkg::SPC_BUSY && busy && !flashOpDone |=> busy)
		else $error("busy cleared during programming");

	window_a: assert property (
		acceptCmd ##1 (!coreReq.store)[*4] |=> !cmd[0])
		else $error("enable outlived its window");

	load_late_a: assert property (
		lock_armed_s ##1 quiet_s [*3] ##1 coreReq.load |=> !loadValid)
		else $error("load answered outside window");

	load_ok_a: assert property (
		lock_armed_s ##1 quiet_s [*2] ##1 coreReq.load |=> loadValid)
		else $error("load in window not answered");

	sig_store_a: assert property (
		acceptCmd && avs_writedata[spc_pkg::SIG_BIT] ##[1:4] coreReq.store
		|=> !flashOp.start && state == spc_pkg::SPC_IDLE)
		else $error("store after signature read acted");

	bad_cmd_a: assert property (
		wrCtrl && !validCmd |=> $stable(cmd))
		else $error("illegal pattern changed control bits");

	addr_latch_a: assert property (
		state == spc_pkg::SPC_BUSY && $past(state == spc_pkg::SPC_BUSY)
		|-> $stable(flashOp.page))
		else $error("page address moved during operation");

	halt_a: assert property (
		flashOp.start && opNrww && flashOp.kind != spc_pkg::SPC_OP_LOCK
		|=> cpuHalt)
		else $error("core not halted for protected page");

endmodule

//--- rtl/spc_pkg.sv
// Shared constants and carrier types for the self-programming flash control.
// Assumes a single 200 MHz system clock and an Avalon-MM register master.
package spc_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses on the Avalon bus)
	// ------------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] BOOT_OFFSET = 4'h4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Control/status bit positions
	localparam int IRQ_EN_BIT = 7;
	localparam int BUSY_BIT = 6;
	localparam int SIG_BIT = 5;

	// Accepted command patterns in the low five control bits
	localparam logic [4:0] CMD_FILL = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;

	// ------------------------------------------------------------------
	// Timing: store window and load window in system clock cycles
	// ------------------------------------------------------------------
	localparam logic [2:0] STORE_WIN = 3'h4;
	localparam logic [2:0] LOAD_WIN = 3'h3;
	localparam logic [2:0] LOAD_LIMIT = STORE_WIN - LOAD_WIN;

	// Reset vectors and pointer width
	localparam int PTR_W = 16;
	localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

	typedef enum {
		SPC_IDLE,
		SPC_ARMED,
		SPC_BUSY
	} spc_state_t;

	typedef enum logic [1:0] {
		SPC_OP_ERASE,
		SPC_OP_WRITE,
		SPC_OP_LOCK
	} spc_op_kind_t;

	// Instruction strobes from the processor core
	typedef struct packed {
		logic store;
		logic load;
		logic [15:0] pointer;
		logic [15:0] dataPair;
	} spc_core_req_t;

	// Operation request towards the flash array
	typedef struct packed {
		logic start;
		spc_op_kind_t kind;
		logic [15:0] page;
		logic [7:0] lockData;
	} spc_flash_op_t;

endpackage

//--- test/spc_flash_model.sv
// Behavioural flash array facing the control block.
// Assumes one start pulse per operation and clk shared with the block.
`timescale 1ns/1ps

module spc_flash_model #(
	parameter logic [7:0] LOCK_VAL = 8'h3c,
	parameter logic [7:0] FUSE_VAL = 8'h5e
) (
	// System
	input wire logic clk,
	input wire logic reset_n,
	// Control side
	input wire spc_pkg::spc_flash_op_t flashOp,
	input wire logic [7:0] opLatency,
	input wire logic [15:0] sigRowAddr,
	output logic flashOpDone,
	output logic [7:0] lockBitsIn,
	output logic [7:0] fuseLowIn,
	output logic [7:0] sigRowData
);
	logic busy;
	logic [7:0] cnt;

	// Fixed stored bytes; signature bytes depend on the row address
	assign lockBitsIn = LOCK_VAL;
	assign fuseLowIn = FUSE_VAL;
	assign sigRowData = sigRowAddr[7:0] ^ 8'ha5;

	// One done pulse per start, after a latency the bench picks
	always_ff @(posedge clk) begin
		flashOpDone <= 1'b0;
		if (!reset_n) begin
			busy <= 1'b0;
			cnt <= 8'h00;
		end else if (flashOp.start) begin
			busy <= 1'b1;
			cnt <= opLatency;
		end else if (busy && cnt == 8'h00) begin
			busy <= 1'b0;
			flashOpDone <= 1'b1;
		end else if (busy) begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule

//--- test/self_programming_flash_control_tb.sv
// Self-checking bench for the self-programming flash control.
// Assumes the flash array model beside it; the bench plays the core.
`timescale 1ns/1ps

module self_programming_flash_control_tb;
	localparam logic [15:0] BOOTA = 16'h3000;
	localparam logic [3:0] CA = spc_pkg::CTRL_OFFSET;
	logic clk, reset_n, avsRead, avsWrite, globalIrqEnable;
	logic [3:0] avsAddress;
	logic [31:0] avsWritedata, avsReaddata, q;
	logic avsWaitrequest, loadValid, cpuHalt, progReadyIrq, rwAreaBlocked;
	logic [7:0] loadData, lockBitsIn, fuseLowIn, sigRowData, opLatency;
	logic bootVectorFuse, hwBootEnableFuse, hwBootPin, flashOpDone;
	logic [15:0] resetVector, sigRowAddr, bufReadData, opPage, expV;
	logic [5:0] bufReadAddr;
	logic [1:0] opKind;
	logic [7:0] opLock;
	spc_pkg::spc_core_req_t coreReq;
	spc_pkg::spc_flash_op_t flashOp;
	int nFail, testsRun, nStart, nLoad, sawHalt, i;
	logic [7:0] bad [5] = '{8'h07, 8'h0b, 8'h13, 8'h1f, 8'h02};

	spc_flash_ctrl #(.BOOT_RESET_ADDR(BOOTA)) u_dut (.clk(clk),
		.reset_n(reset_n), .avs_address(avsAddress), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
		.coreReq(coreReq), .globalIrqEnable(globalIrqEnable),
		.loadValid(loadValid), .loadData(loadData), .cpuHalt(cpuHalt),
		.progReadyIrq(progReadyIrq), .rwAreaBlocked(rwAreaBlocked),
		.bootVectorFuse(bootVectorFuse), .hwBootEnableFuse(hwBootEnableFuse),
		.hwBootPin(hwBootPin), .resetVector(resetVector), .flashOp(flashOp),
		.flashOpDone(flashOpDone), .lockBitsIn(lockBitsIn),
		.fuseLowIn(fuseLowIn), .sigRowData(sigRowData),
		.sigRowAddr(sigRowAddr), .bufReadAddr(bufReadAddr),
		.bufReadData(bufReadData));

	spc_flash_model u_flash (.clk(clk), .reset_n(reset_n), .flashOp(flashOp),
		.opLatency(opLatency), .sigRowAddr(sigRowAddr),
		.flashOpDone(flashOpDone), .lockBitsIn(lockBitsIn),
		.fuseLowIn(fuseLowIn), .sigRowData(sigRowData));

	// ------------------------------------------------------------------
	// Clock, monitors and watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Record every operation start and load answer the block launches
	always @(posedge clk) begin
		if (flashOp.start === 1'b1) begin
			nStart++;
			opKind = flashOp.kind;
			opPage = flashOp.page;
			opLock = flashOp.lockData;
		end
		if (loadValid === 1'b1) nLoad++;
		if (cpuHalt === 1'b1) sawHalt = 1;
	end

	// Whole run is a few hundred cycles; this span is far beyond it
	initial begin
		#100000;
		nFail++;
		test_done();
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		testsRun++;
		if (g !== e) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		avsAddress <= a;
		avsWrite <= w;
		avsRead <= !w;
		avsWritedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 50);
		q = avsReaddata;
		if (n >= 50) chk("waitrequest", 0, 1);
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("readdata", e, q);
	endtask

	// One store or load strobe with its pointer and data pair
	task automatic core(input logic s, l, input logic [15:0] p, d);
		@(posedge clk);
		coreReq <= '{store: s, load: l, pointer: p, dataPair: d};
		@(posedge clk);
		coreReq.store <= 1'b0;
		coreReq.load <= 1'b0;
	endtask

	// Pointer settles before the command, as the core's pointer would
	task automatic cmd(input logic [7:0] c, input logic s,
		input logic [15:0] p, d);
		coreReq.pointer <= p;
		bus(1'b1, CA, {24'h0, c});
		core(s, !s, p, d);
		repeat (2) @(posedge clk);
	endtask

	task automatic bufchk(input logic [5:0] a, input logic [15:0] e);
		@(posedge clk);
		bufReadAddr <= a;
		repeat (2) @(posedge clk);
		#1 chk("bufReadData", e, bufReadData);
	endtask

	task automatic waitDone();
		int n;
		n = 0;
		while (flashOpDone !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) chk("flashOpDone", 1, 0);
		repeat (3) @(posedge clk);
	endtask

	task automatic rst(input logic bv, he, pin);
		bootVectorFuse <= bv;
		hwBootEnableFuse <= he;
		hwBootPin <= pin;
		reset_n <= 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		{reset_n, avsRead, avsWrite, globalIrqEnable} = 4'h0;
		{avsAddress, avsWritedata, coreReq, bufReadAddr} = '0;
		{bootVectorFuse, hwBootEnableFuse, hwBootPin} = 3'h7;
		opLatency = 8'h14;
		for (i = 0; i < 8; i++) begin
			rst(i[2], i[1], i[0]);
			expV = (!i[2] || (!i[1] && !i[0])) ? BOOTA : 16'h0000;
			chk("resetVector", expV, resetVector);
		end
		rdchk(CA, spc_pkg::CTRL_RESET);
		bus(1'b1, spc_pkg::BOOT_OFFSET, 32'h3000);
		rdchk(spc_pkg::BOOT_OFFSET, 0);
		rdchk(4'h8, 0);
		$display("test reset and fuses done");
		// Undefined patterns change nothing and launch nothing
		for (i = 0; i < 5; i++) begin
			cmd(bad[i], 1'b1, 16'h0100, 16'h0000);
			rdchk(CA, 0);
		end
		chk("starts", 0, nStart);
		// Erase in the read-while-write area, then pointer moves on
		cmd(spc_pkg::CMD_ERASE, 1'b1, 16'h0145, 16'hffff);
		coreReq.pointer <= 16'h2fff;
		rdchk(CA, 32'h43);
		chk("opPage", 16'h0100, opPage);
		chk("opKind", spc_pkg::SPC_OP_ERASE, opKind);
		chk("page held", 16'h0100, flashOp.page);
		bus(1'b1, CA, spc_pkg::CMD_REEN);
		rdchk(CA, 32'h43);
		waitDone();
		rdchk(CA, 32'h40);
		chk("blocked", 1, rwAreaBlocked);
		cmd(spc_pkg::CMD_REEN, 1'b1, 16'h0000, 16'h0000);
		rdchk(CA, 0);
		chk("blocked", 0, rwAreaBlocked);
		$display("test erase and re-enable done");
		// Second erase; a buffer fill clears busy this time
		cmd(spc_pkg::CMD_ERASE, 1'b1, 16'h0100, 16'h0000);
		waitDone();
		cmd(spc_pkg::CMD_FILL, 1'b1, 16'h0005, 16'h1234);
		rdchk(CA, 0);
		cmd(spc_pkg::CMD_FILL, 1'b1, 16'h0004, 16'h5678);
		bufchk(6'h02, 16'h1234);
		cmd(spc_pkg::CMD_FILL, 1'b1, 16'h0006, 16'habcd);
		cmd(spc_pkg::CMD_REEN, 1'b1, 16'h0000, 16'h0000);
		bufchk(6'h03, 16'h0000);
		bufchk(6'h02, 16'h0000);
		// Store window: fourth edge accepted, fifth refused
		bus(1'b1, CA, spc_pkg::CMD_FILL);
		repeat (2) @(posedge clk);
		core(1'b1, 1'b0, 16'h0008, 16'h4444);
		bus(1'b1, CA, spc_pkg::CMD_FILL);
		repeat (3) @(posedge clk);
		core(1'b1, 1'b0, 16'h000c, 16'h7777);
		bufchk(6'h04, 16'h4444);
		bufchk(6'h06, 16'h0000);
		$display("test buffer done");
		// Page write to the no-read-while-write area, prompt answer
		opLatency = 8'h05;
		sawHalt = 0;
		cmd(spc_pkg::CMD_WRITE, 1'b1, 16'h3040, 16'h0000);
		chk("opKind", spc_pkg::SPC_OP_WRITE, opKind);
		chk("opPage", 16'h3000, opPage);
		waitDone();
		chk("sawHalt", 1, sawHalt);
		chk("cpuHalt", 0, cpuHalt);
		bufchk(6'h04, 16'h0000);
		// Lock programming, then lock, fuse and signature reads
		cmd(spc_pkg::CMD_LOCK, 1'b1, 16'hbeef, 16'hffc3);
		chk("opKind", spc_pkg::SPC_OP_LOCK, opKind);
		chk("opLock", 8'hc3, opLock);
		waitDone();
		cmd(spc_pkg::CMD_LOCK, 1'b0, 16'h0001, 16'h0000);
		chk("loadData", 8'h3c, loadData);
		cmd(spc_pkg::CMD_LOCK, 1'b0, 16'h0000, 16'h0000);
		chk("loadData", 8'h5e, loadData);
		cmd(8'h21, 1'b0, 16'h0002, 16'h0000);
		chk("loadData", 8'ha7, loadData);
		chk("nLoad", 3, nLoad);
		// Lock load window: third edge answered, fourth refused
		bus(1'b1, CA, spc_pkg::CMD_LOCK);
		@(posedge clk);
		core(1'b0, 1'b1, 16'h0001, 16'h0000);
		bus(1'b1, CA, spc_pkg::CMD_LOCK);
		repeat (2) @(posedge clk);
		core(1'b0, 1'b1, 16'h0000, 16'h0000);
		repeat (2) @(posedge clk);
		chk("nLoad", 4, nLoad);
		chk("loadData", 8'h3c, loadData);
		cmd(8'h21, 1'b1, 16'h000a, 16'h9999);
		bufchk(6'h05, 16'h0000);
		chk("starts", 4, nStart);
		$display("test lock and signature done");
		// Ready interrupt follows enable bits and the store enable
		bus(1'b1, CA, 32'h80);
		globalIrqEnable <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irq", 1, progReadyIrq);
		globalIrqEnable <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq", 0, progReadyIrq);
		globalIrqEnable <= 1'b1;
		opLatency = 8'h14;
		cmd(8'h83, 1'b1, 16'h0200, 16'h0000);
		chk("irq", 0, progReadyIrq);
		waitDone();
		chk("irq", 1, progReadyIrq);
		$display("test interrupt done");
		test_done();
	end
endmodule
